// ==== common/sph_regs.vh ====
`ifndef SPH_REGS_VH
`define SPH_REGS_VH
// page map as seen from the reader side (2k variant, sector 1 carries the buffer)
`define SPH_SECTOR_USER 2'h0
`define SPH_SECTOR_LOCK 2'h1
`define SPH_SECTOR_SESS 2'h3
`define SPH_PAGE_DYNLOCK 8'he0
`define SPH_PAGE_CFG0 8'he8
`define SPH_PAGE_CFG1 8'he9
`define SPH_PAGE_SESS0 8'hf8
`define SPH_PAGE_SESS1 8'hf9
`define SPH_PAGE_HOLE_LO 8'he1
`define SPH_PAGE_HOLE_HI 8'he7
`define SPH_PAGE_USER_LAST 8'hdf
`define SPH_SRAM_BASE_HI 4'hf
`define SPH_TERM_IDX 4'hf
`define SPH_LOCK_BYTE3 8'h00
// detect-event select and arbiter state encodings, two bits each
`define SPH_FD_SEL_BUF 2'h3
`define SPH_FD_REL_BUF 2'h3
`define SPH_ARB_IDLE 2'h0
`define SPH_ARB_READER 2'h1
`define SPH_ARB_HOST 2'h2
`endif

// ==== hdl/sph_pulse.v ====
`timescale 1ns/1ps
// stretches a one-cycle event into a pulse of fixed length
module sph_pulse #(
  parameter LEN = 4
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // event in, pulse out
  input wire trig,
  output reg pulse_reg
);
  reg [7:0] cnt_reg;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_reg <= 8'h00;
      pulse_reg <= 1'b0;
    end else if (trig) begin
      cnt_reg <= LEN[7:0];
      pulse_reg <= 1'b1;
    end else if (cnt_reg > 8'h01) begin
      cnt_reg <= cnt_reg - 8'h01;
    end else begin
      cnt_reg <= 8'h00;
      pulse_reg <= 1'b0;
    end
  end
endmodule // sph_pulse

// ==== hdl/sph_handshake.v ====
`timescale 1ns/1ps
`include "sph_regs.vh"
// Functional notes
// - a reader write to the last buffer page while the reader owns the buffer flags it ready for the host and hands over.
// - with the detect select enabled, the detect output pulses when buffered data awaits the host.
// - a correct host slave address sets host ownership, if the arbiter allows it.
// - a host read of the last buffer page clears host-ready and host ownership, returning to idle.
// - a host write to the last buffer page while the host owns it flags it ready for the reader and goes idle.
// - after a host-to-reader handoff, the reader ownership bit is set, if the arbiter allows it.
// - a reader read touching the last buffer page clears reader-ready and reader ownership.
// - with the detect select enabled, the detect output pulses when the reader has drained the buffer.
// - the dynamic lock bytes sit in bytes 0 to 2 of sector 1 page e0, byte 3 reads 00.
// - reader accesses to holes, including sector 3 outside the session pages, are refused with a nak.
// - sector 3 pages f8 and f9 decode as the session register pages.
// - in transfer mode the 64-byte buffer is mirrored onto pages f0 to ff of sector 1.
// - the sixteenth buffer page is the terminator page.
// - transfer mode drops automatically when either interface loses power.
module sph_handshake #(
  parameter FD_PULSE_LEN = 4
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // power and mode
  input wire reader_power_ok,
  input wire host_power_ok,
  input wire transfer_mode_set,
  input wire transfer_mode_clr,
  input wire [1:0] detect_assert_select,
  input wire [1:0] detect_release_select,
  // reader side access, valid for one cycle at command end
  input wire rd_req,
  input wire rd_write,
  input wire [1:0] rd_sector,
  input wire [7:0] rd_page,
  input wire [7:0] rd_page_last,
  input wire [31:0] rd_wdata,
  // host side access
  input wire host_addr_match,
  input wire host_req,
  input wire host_write,
  input wire [3:0] host_page,
  input wire [31:0] host_wdata,
  // dynamic lock store contents
  input wire [23:0] dyn_lock_bytes,
  // answers
  output reg rd_ack_reg,
  output reg rd_nak_reg,
  output reg [31:0] rd_rdata_reg,
  output reg [1:0] rd_region_reg,
  output reg host_ack_reg,
  output reg host_nak_reg,
  output reg [31:0] host_rdata_reg,
  // status
  output reg transfer_mode_enable,
  output reg reader_owns_arbitration,
  output reg host_owns_arbitration,
  output reg buffer_ready_for_reader,
  output reg buffer_ready_for_host,
  output wire field_detect_output
);
  // region codes reported on the reader side
  localparam REG_SRAM = 2'h0;
  localparam REG_LOCK = 2'h1;
  localparam REG_CFG = 2'h2;
  localparam REG_SESS = 2'h3;

  reg [31:0] sram_mem [0:15];
  reg pend_reader_reg;
  wire both_pwr = reader_power_ok & host_power_ok;
  wire rd_sram = (rd_sector == `SPH_SECTOR_LOCK) &&
    (rd_page[7:4] == `SPH_SRAM_BASE_HI) && transfer_mode_enable;
  wire rd_lock = (rd_sector == `SPH_SECTOR_LOCK) && (rd_page == `SPH_PAGE_DYNLOCK);
  wire rd_cfg = (rd_sector == `SPH_SECTOR_LOCK) &&
    ((rd_page == `SPH_PAGE_CFG0) || (rd_page == `SPH_PAGE_CFG1));
  wire rd_sess = (rd_sector == `SPH_SECTOR_SESS) &&
    ((rd_page == `SPH_PAGE_SESS0) || (rd_page == `SPH_PAGE_SESS1));
  wire rd_user = (rd_sector == `SPH_SECTOR_USER) ||
    ((rd_sector == `SPH_SECTOR_LOCK) && (rd_page <= `SPH_PAGE_USER_LAST));
  wire rd_valid = rd_sram | rd_lock | rd_cfg | rd_sess | rd_user;
  // reader may touch buffer when idle or owning it
  wire rd_buf_ok = !host_owns_arbitration;
  wire rd_term_w = rd_sram && rd_write && (rd_page[3:0] == `SPH_TERM_IDX);
  // a multi-page read spanning up to the last page also counts
  wire rd_term_r = rd_sram && !rd_write &&
    ((rd_page[3:0] == `SPH_TERM_IDX) || (rd_page_last[3:0] == `SPH_TERM_IDX));
  wire host_buf_ok = transfer_mode_enable && !reader_owns_arbitration;
  wire host_term = host_page == `SPH_TERM_IDX;
  wire rd_go = rd_req && rd_valid && !(rd_sram && !rd_buf_ok);
  wire host_go = host_req && host_buf_ok && host_owns_arbitration;
  wire ev_to_host = rd_go && rd_term_w && reader_owns_arbitration;
  wire ev_drained = rd_go && rd_term_r;
  wire fd_trig = (ev_to_host && (detect_assert_select == `SPH_FD_SEL_BUF)) ||
    (ev_drained && (detect_release_select == `SPH_FD_REL_BUF));

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      transfer_mode_enable <= 1'b0;
    end else if (!both_pwr) begin
      transfer_mode_enable <= 1'b0;
    end else if (transfer_mode_set) begin
      transfer_mode_enable <= 1'b1;
    end else if (transfer_mode_clr) begin
      transfer_mode_enable <= 1'b0;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b || !transfer_mode_enable) begin
      reader_owns_arbitration <= 1'b0;
      host_owns_arbitration <= 1'b0;
      buffer_ready_for_reader <= 1'b0;
      buffer_ready_for_host <= 1'b0;
      pend_reader_reg <= 1'b0;
    end else begin
      if (ev_to_host) begin
        buffer_ready_for_host <= 1'b1;
        reader_owns_arbitration <= 1'b0;
        host_owns_arbitration <= 1'b1;
      end else if (ev_drained) begin
        buffer_ready_for_reader <= 1'b0;
        reader_owns_arbitration <= 1'b0;
      end else if (rd_go && rd_sram && !reader_owns_arbitration && !host_owns_arbitration) begin
        reader_owns_arbitration <= 1'b1; // first come, first served
      end else if (pend_reader_reg && !host_owns_arbitration) begin
        reader_owns_arbitration <= 1'b1;
        pend_reader_reg <= 1'b0;
      end
      if (host_go && host_term && host_write) begin
        buffer_ready_for_reader <= 1'b1;
        host_owns_arbitration <= 1'b0;
        pend_reader_reg <= 1'b1;
      end else if (host_go && host_term) begin
        buffer_ready_for_host <= 1'b0;
        host_owns_arbitration <= 1'b0;
      end else if (host_addr_match && !reader_owns_arbitration && !ev_to_host && !pend_reader_reg &&
        !(rd_go && rd_sram)) begin
        // a reader claim in the same cycle wins, so both sides never own the buffer at once
        host_owns_arbitration <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (rd_go && rd_sram && rd_write) begin
      sram_mem[rd_page[3:0]] <= rd_wdata;
    end else if (host_go && host_write) begin
      sram_mem[host_page] <= host_wdata;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      rd_ack_reg <= 1'b0;
      rd_nak_reg <= 1'b0;
      rd_rdata_reg <= 32'h00000000;
      rd_region_reg <= REG_SRAM;
      host_ack_reg <= 1'b0;
      host_nak_reg <= 1'b0;
      host_rdata_reg <= 32'h00000000;
    end else begin
      rd_ack_reg <= rd_go;
      rd_nak_reg <= rd_req && !rd_go;
      host_ack_reg <= host_go;
      host_nak_reg <= host_req && !host_go;
      rd_region_reg <= rd_lock ? REG_LOCK : rd_cfg ? REG_CFG : rd_sess ? REG_SESS : REG_SRAM;
      if (rd_go && rd_lock) begin
        rd_rdata_reg <= {`SPH_LOCK_BYTE3, dyn_lock_bytes};
      end else if (rd_go && rd_sess) begin
        // session status bits the reader polls
        rd_rdata_reg <= {27'h0000000, buffer_ready_for_host, buffer_ready_for_reader,
          host_owns_arbitration, reader_owns_arbitration, transfer_mode_enable};
      end else if (rd_go && rd_sram) begin
        rd_rdata_reg <= sram_mem[rd_page[3:0]];
      end else begin
        rd_rdata_reg <= 32'h00000000;
      end
      if (host_go) begin
        host_rdata_reg <= sram_mem[host_page];
      end
    end
  end

  sph_pulse #(
    .LEN(FD_PULSE_LEN)
  ) u_fd (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .trig(fd_trig),
    .pulse_reg(field_detect_output)
  );
endmodule // sph_handshake

// ==== dv/sph_host_model.sv ====
`timescale 1ns/1ps
// host controller: polls the host-ready flag, drains the buffer, then writes a reply back
module sph_host_model (
  // clock and device status
  input wire logic clk_sys,
  input wire logic ready_host,
  input wire logic [31:0] rdata,
  // host requests
  output logic addr_match,
  output logic req,
  output logic wr,
  output logic [3:0] page,
  output logic [31:0] wdata,
  output logic [31:0] first_word
);
  int step = 0;
  initial {addr_match, req, wr, page, wdata, first_word} = '0;
  always @(negedge clk_sys) begin
    {addr_match, req, wr} = 3'b000;
    // released lines wander so a stale value is never mistaken for a request
    {page, wdata} = ~{page, wdata};
    step = (step == 0) ? int'(ready_host === 1'b1) : step + 1;
    case (step)
      1, 6: addr_match = 1'b1;
      2: {req, page} = {1'b1, 4'h0};
      4: {req, page, first_word} = {1'b1, 4'hf, rdata};
      7: {req, wr, page, wdata} = {2'b11, 4'hf, ~first_word};
      8: step = 0;
    endcase
  end
endmodule // sph_host_model

// ==== dv/sph_handshake_assertions.sv ====
`timescale 1ns/1ps
module sph_checker (
  // clock, reset, mode
  input logic clk_sys, rst_b, reader_power_ok, host_power_ok, transfer_mode_enable,
  input logic [1:0] detect_assert_select, detect_release_select,
  // requests
  input logic rd_req, rd_write, host_addr_match,
  input logic [1:0] rd_sector,
  input logic [7:0] rd_page, rd_page_last,
  input logic [23:0] dyn_lock_bytes,
  // answers and status
  input logic rd_ack_reg, rd_nak_reg, field_detect_output,
  input logic [31:0] rd_rdata_reg,
  input logic reader_owns_arbitration, host_owns_arbitration, buffer_ready_for_reader, buffer_ready_for_host
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire buf_pg = rd_sector == 2'h1 && rd_page[7:4] == 4'hf;
  wire hole = rd_sector == 2'h2 || (rd_sector == 2'h3 && rd_page != 8'hf8 && rd_page != 8'hf9);
  sequence term_wr;
    rd_req && rd_write && buf_pg && rd_page[3:0] == 4'hf;
  endsequence
  sequence handed;
    buffer_ready_for_host && host_owns_arbitration && !reader_owns_arbitration;
  endsequence
  reader_hand_a: assert property (reader_owns_arbitration && transfer_mode_enable ##0 term_wr |=> handed)
    else $error("reader handoff missed");
  host_claim_a: assert property (host_addr_match && transfer_mode_enable && !reader_owns_arbitration &&
    !buffer_ready_for_reader && !(rd_req && buf_pg) |=> host_owns_arbitration) else $error("host not made owner");
  reader_claim_a: assert property ($rose(buffer_ready_for_reader) |-> ##[0:2] reader_owns_arbitration)
    else $error("reader not made owner");
  reader_done_a: assert property (reader_owns_arbitration && rd_req && !rd_write && buf_pg &&
    rd_page_last == 8'hff |=> !buffer_ready_for_reader && !reader_owns_arbitration) else $error("drain");
  hole_nak_a: assert property (rd_req && hole |=> rd_nak_reg && !rd_ack_reg) else $error("hole answered");
  lock_page_a: assert property (rd_req && !rd_write && rd_sector == 2'h1 && rd_page == 8'he0 |=>
    rd_ack_reg && rd_rdata_reg == {8'h00, $past(dyn_lock_bytes)}) else $error("lock page data");
  owner_refuse_a: assert property (host_owns_arbitration && rd_req && buf_pg |=> rd_nak_reg)
    else $error("reader let in");
  ready_pulse_a: assert property ($rose(buffer_ready_for_host) && detect_assert_select == 2'h3 |->
    ##[0:3] field_detect_output) else $error("no data-ready pulse");
  drain_pulse_a: assert property ($fell(buffer_ready_for_reader) && transfer_mode_enable &&
    detect_release_select == 2'h3 |-> ##[0:3] field_detect_output) else $error("no drained pulse");
  power_drop_a: assert property (!(reader_power_ok && host_power_ok) |=> !transfer_mode_enable)
    else $error("mode kept without power");
endmodule // sph_checker
bind sph_handshake sph_checker u_sph_checker (.*);

// ==== dv/test_sph_handshake.sv ====
`timescale 1ns/1ps
module test_sph_handshake;
  logic clk_sys = 1'b0, rst_b = 1'b0, reader_power_ok = 1'b1, host_power_ok = 1'b1;
  logic transfer_mode_set = 1'b0, transfer_mode_clr = 1'b0, rd_req = 1'b0, rd_write = 1'b0;
  logic [1:0] detect_assert_select = 2'h3, detect_release_select = 2'h3, rd_sector = 2'h0;
  logic [7:0] rd_page = 8'h00, rd_page_last = 8'h00;
  logic [31:0] rd_wdata = 32'h0;
  logic [23:0] dyn_lock_bytes = 24'h5a3c81;
  wire host_addr_match, host_req, host_write, rd_ack_reg, rd_nak_reg, host_ack_reg, host_nak_reg;
  wire transfer_mode_enable, reader_owns_arbitration, host_owns_arbitration, field_detect_output;
  wire buffer_ready_for_reader, buffer_ready_for_host;
  wire [3:0] host_page;
  wire [1:0] rd_region_reg;
  wire [31:0] host_wdata, rd_rdata_reg, host_rdata_reg, first_word;
  int miscompares = 0, checks_done = 0, fd_seen = 0;
  always #2.5 clk_sys = ~clk_sys;
  int host_acks = 0, host_naks = 0;
  always @(posedge field_detect_output) fd_seen++;
  always @(negedge clk_sys) begin
    host_acks += host_ack_reg;
    host_naks += host_nak_reg;
  end
  sph_handshake u_sph_handshake (.*);
  sph_host_model u_sph_host_model (.clk_sys(clk_sys), .ready_host(buffer_ready_for_host), .rdata(host_rdata_reg),
    .addr_match(host_addr_match), .req(host_req), .wr(host_write), .page(host_page), .wdata(host_wdata),
    .first_word(first_word));
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task hung;
    miscompares++;
    $display("ERROR wait expected answer seen none");
    close_out;
  endtask
  // one reader command end; returns {ack, nak} and read data
  task rd(input logic w, input logic [1:0] s, input logic [7:0] p, pl, input logic [31:0] wd,
    output logic [1:0] an, output logic [31:0] d);
    int i;
    @(negedge clk_sys);
    {rd_req, rd_write, rd_sector, rd_page, rd_page_last, rd_wdata} = {1'b1, w, s, p, pl, wd};
    @(negedge clk_sys) rd_req = 1'b0;
    for (i = 0; i < 4 && (rd_ack_reg | rd_nak_reg) !== 1'b1; i++) @(negedge clk_sys);
    if (i == 4) hung;
    an = {rd_ack_reg, rd_nak_reg};
    d = rd_rdata_reg;
  endtask
  task t_map;
    logic [1:0] an;
    logic [31:0] d;
    logic [9:0] holes [6] = '{10'h300, 10'h3ff, 10'h3fa, 10'h210, 10'h1e4, 10'h1ea};
    rd(0, 2'h1, 8'he0, 8'he0, 0, an, d);
    chk("lock data", {8'h00, dyn_lock_bytes}, d);
    chk("lock region", 2'h1, rd_region_reg);
    rd(0, 2'h3, 8'hf9, 8'hf9, 0, an, d);
    chk("session status", 32'h1, d);
    chk("session region", 2'h3, rd_region_reg);
    foreach (holes[k]) begin
      rd(0, holes[k][9:8], holes[k][7:0], holes[k][7:0], 0, an, d);
      chk("hole answer", 2'b01, an);
    end
  endtask
  task t_pass;
    logic [1:0] an;
    logic [31:0] d;
    int i;
    rd(1, 2'h1, 8'hf0, 8'hf0, 32'hc0ffee11, an, d);
    rd(1, 2'h1, 8'hff, 8'hff, 32'h0, an, d);
    chk("host ready", 3'b110, {buffer_ready_for_host, host_owns_arbitration, reader_owns_arbitration});
    rd(0, 2'h1, 8'hf0, 8'hf0, 0, an, d);
    chk("other side", 2'b01, an);
    for (i = 0; i < 40 && buffer_ready_for_reader !== 1'b1; i++) @(negedge clk_sys);
    if (i == 40) hung;
    chk("host released", 2'b00, {buffer_ready_for_host, host_owns_arbitration});
    chk("mirror", 32'hc0ffee11, first_word);
    repeat (3) @(negedge clk_sys);
    chk("reader owner", 1, reader_owns_arbitration);
    chk("ready pulses", 1, fd_seen);
    rd(0, 2'h3, 8'hf8, 8'hf8, 0, an, d);
    chk("reader poll", 32'hb, d);
    chk("host accesses", 3, host_acks);
    chk("host refusals", 0, host_naks);
    rd(0, 2'h1, 8'hf0, 8'hff, 0, an, d);
    chk("reader drained", 2'b00, {buffer_ready_for_reader, reader_owns_arbitration});
    repeat (5) @(negedge clk_sys);
    chk("drain pulses", 2, fd_seen);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys) transfer_mode_set = 1'b1;
    @(negedge clk_sys) transfer_mode_set = 1'b0;
    chk("mode on", 1, transfer_mode_enable);
    t_map;
    t_pass;
    host_power_ok = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("mode off", 0, transfer_mode_enable);
    close_out;
  end
endmodule // test_sph_handshake
